// ---- lcd_pkg.sv ----
package lcd_pkg;

  // Configuration offsets
  localparam logic [7:0] OFS_SETUP_PRI  = 8'h50;
  localparam logic [7:0] OFS_SETUP_SEC  = 8'h51;
  localparam logic [7:0] OFS_BIOS_CTL   = 8'h52;
  localparam logic [7:0] OFS_PERF       = 8'h53;
  localparam logic [7:0] OFS_WIN1_LO    = 8'h54;
  localparam logic [7:0] OFS_WIN1_HI    = 8'h55;
  localparam logic [7:0] OFS_WIN2_LO    = 8'h56;
  localparam logic [7:0] OFS_WIN2_HI    = 8'h57;
  localparam logic [7:0] OFS_MAP_LO     = 8'h58;
  localparam logic [7:0] OFS_MAP_HI     = 8'h59;

  // Reset values
  localparam logic [7:0]  RST_SETUP_PRI = 8'h20;
  localparam logic [7:0]  RST_SETUP_SEC = 8'h00;
  localparam logic [7:0]  RST_BIOS_CTL  = 8'h02;
  localparam logic [7:0]  RST_PERF      = 8'h00;
  localparam logic [15:0] RST_WIN       = 16'h0000;
  localparam logic [7:0]  RST_MAP_LO    = 8'h40;
  localparam logic [7:0]  RST_MAP_HI    = 8'h05;

  // Writable bit masks, other bits read zero
  localparam logic [7:0] WM_SETUP_PRI   = 8'hFB;
  localparam logic [7:0] WM_SETUP_SEC   = 8'h2B;
  localparam logic [7:0] WM_BIOS_CTL    = 8'hF7;
  localparam logic [7:0] WM_PERF        = 8'hF8;
  localparam logic [7:0] WM_MAP_LO      = 8'hEE;
  localparam logic [7:0] WM_MAP_HI      = 8'hE7;

  // Field positions
  localparam int MODE_LSB   = 6;
  localparam int TAG_LSB    = 3;
  localparam int SRAM_LSB   = 0;
  localparam int BUS_BACKOFF_REQUEST_BIT   = 5;
  localparam int BANKS_BIT  = 3;
  localparam int SIZE_LSB   = 0;
  localparam int WPC_BIT    = 7;
  localparam int WPD_BIT    = 6;
  localparam int WPE_BIT    = 5;
  localparam int WPF_BIT    = 4;
  localparam int FILL_BIT   = 2;
  localparam int WPOL_BIT   = 0;
  localparam int RAW_BIT    = 7;
  localparam int CACHE_READ_PIPELINING_BIT   = 6;
  localparam int CACHE_WRITE_PIPELINING_BIT   = 5;
  localparam int DPC_BIT    = 4;
  localparam int PEER_BIT   = 3;
  localparam int WSIZE_LSB  = 8;
  localparam int MAPA_LSB   = 5;
  localparam int MAPB_LSB   = 1;
  localparam int LAST_LSB   = 0;

  // Encodings
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_INIT   = 2'h1;
  localparam logic [1:0] MODE_NORMAL = 2'h2;
  localparam logic [1:0] TAG_8_0     = 2'h0;
  localparam logic [1:0] TAG_7_1     = 2'h1;
  localparam logic [1:0] TAG_10_1    = 2'h2;
  localparam logic [1:0] TAG_9_1     = 2'h3;
  localparam logic [1:0] SRAM_NONE   = 2'h0;
  localparam logic [1:0] SRAM_BURST  = 2'h2;
  localparam logic [1:0] SRAM_PIPE   = 2'h3;
  localparam logic [2:0] MAP_MAX     = 3'h4;
  localparam logic [2:0] BANK_MAX    = 3'h5;
  localparam logic [3:0] COL_MIN     = 4'h8;
  localparam logic [11:0] SIZE_MIN_KB = 12'h100;
  localparam logic [1:0] LEAD_CLOCKS = 2'h3;
  localparam logic [1:0] SWITCH_CLOCKS = 2'h2;
  localparam logic [1:0] BURST_CLOCKS  = 2'h1;
  localparam logic [2:0] SWITCH_BEAT   = 3'h4;
  localparam int COL_LSB   = 3;
  localparam int PC_LINE   = 10;

  typedef struct packed {
    logic [7:0]  setup_pri;
    logic [7:0]  setup_sec;
    logic [7:0]  bios_ctl;
    logic [7:0]  perf;
    logic [15:0] win1;
    logic [15:0] win2;
    logic [7:0]  map_lo;
    logic [7:0]  map_hi;
    logic [7:0]  rdata;
    logic        l2_enabled;
    logic        l2_init;
    logic [3:0]  tag_bits;
    logic        tag_modify;
    logic        sram_present;
    logic        sram_pipelined;
    logic [11:0] size_kb;
    logic        allocate;
    logic        l2_write;
    logic        dram_write;
    logic        write_through;
    logic        burst_ready_strobe;
    logic        bus_backoff_request;
    logic        read_first;
    logic        na;
    logic        pci_grant;
    logic        bank_cacheable;
    logic        populated;
    logic [3:0]  col_bits;
    logic        sdram_64m;
    logic [13:0] ma;
    logic [1:0]  beat_clocks;
  } lcd_state_t;

endpackage

// ---- lcd_config.sv ----
`timescale 1ns/1ps
// Behaviour
// - Mode field: 00 off, 01 init fill, 10 normal, 11 reserved.
// - Tag field picks 8+0, 7+1, 10+1 or 9+1 tag layout.
// - SRAM type: 00 none, 01 reserved, 10 burst, 11 pipelined burst.
// - Forced fill stalls by withholding burst ready or asserting backoff.
// - Bank count; read hit 3-1-1-1, two banks add a clock at switch.
// - Size field 00..11 gives 256K, 512K, 1M, 2M; resets to 256K.
// - Bits 7..4 protect C, D, E, F BIOS segments; clear means uncached.
// - Protected segment reads allocate; writes skip L2, go to DRAM.
// - Forced fill allocates despite inactive cacheable pin, honours own regions.
// - Write policy bit: clear write-back, set write-through.
// - Read-around-write lets reads pass queued writes; else arrival order.
// - Three pipelining enables; next-address only on pipelined cycles.
// - Without peer concurrency PCI initiators get memory; with it they bypass.
// - Window base: bits 15-11 are A20..A16, bits 7-0 are A28..A21.
// - Window size 000 off, 001 64K doubling to 111 4M; base aligned.
// - EDO/FPM map type 000..100 gives 8..12 column bits per bank pair.
// - SDRAM map type top bit: 0 for 16-Mbit, 1 for 64-Mbit.
// - SDRAM bank select on line 11 two-bank, line 13 four-bank.
// - Precharge flag zero on page hit, one on miss or all-bank precharge.
// - Last populated bank field 000..101, default 101, 110-111 reserved.
// - Banks 0,1,5 cacheable; 2,3,4 uncached under 10+1 tag layout.
module lcd_config (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // Configuration access
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic        cfg_wr_in,
  input  wire logic        cfg_rd_in,
  input  wire logic [7:0]  cfg_wdata_in,
  output logic      [7:0]  cfg_rdata_out,
  // Host cycle
  input  wire logic [31:0] hst_addr_in,
  input  wire logic        hst_read_in,
  input  wire logic        hst_write_in,
  input  wire logic        cpu_cacheable_in,
  input  wire logic [2:0]  bank_index_in,
  input  wire logic [2:0]  beat_in,
  input  wire logic        fill_active_in,
  input  wire logic        burst_ready_strobe_request_in,
  input  wire logic        wbuf_pending_in,
  input  wire logic        pipe_read_hit_in,
  input  wire logic        pipe_write_in,
  input  wire logic        pipe_dram_in,
  input  wire logic        pci_initiator_active_in,
  // DRAM addressing
  input  wire logic        sdram_bank_in,
  input  wire logic        sdram_four_bank_in,
  input  wire logic        column_phase_in,
  input  wire logic        page_hit_in,
  input  wire logic        all_bank_precharge_in,
  // Cache status
  output logic             l2_enabled_out,
  output logic             l2_init_out,
  output logic      [3:0]  tag_bits_out,
  output logic             tag_modify_out,
  output logic             sram_present_out,
  output logic             sram_pipelined_out,
  output logic      [11:0] l2_size_kb_out,
  output logic      [1:0]  beat_clocks_out,
  // Cycle decisions
  output logic             l2_allocate_out,
  output logic             l2_write_out,
  output logic             dram_write_out,
  output logic             write_through_out,
  output logic             read_first_out,
  output logic             pci_memory_grant_out,
  output logic             bank_cacheable_out,
  output logic             bank_populated_out,
  // Processor bus
  output logic             burst_ready_strobe_out,
  output logic             bus_backoff_request_out,
  output logic             next_address_request_out,
  // Memory address
  output logic      [3:0]  column_bits_out,
  output logic             sdram_64m_out,
  output logic      [13:0] memory_address_line_out
);

  lcd_pkg::lcd_state_t s_q;
  lcd_pkg::lcd_state_t s_d;

  logic [1:0]  mode;
  logic [1:0]  tag;
  logic        forced_fill;
  logic        in_c;
  logic        in_d;
  logic        in_e;
  logic        in_f;
  logic        seg_any;
  logic        seg_prot;
  logic        win1_hit;
  logic        win2_hit;
  logic [2:0]  map_type;
  logic [3:0]  col;
  logic [31:0] row_addr;
  logic [13:0] col_mask;

  function automatic logic win_match(input logic [15:0] w, input logic [31:0] a);
    logic [12:0] base;
    logic [12:0] mask;
    logic [2:0]  sz;
    base = {w[7:0], w[15:11]};
    sz   = w[10:8];
    mask = 13'h1FFF << (sz - 3'h1);
    win_match = (sz != 3'h0) && (a[31:29] == 3'h0) && (((a[28:16] ^ base) & mask) == 13'h0000);
  endfunction

  always_comb begin
    s_d = s_q;
    // Register writes
    if (cfg_wr_in) begin
      case (cfg_addr_in)
        lcd_pkg::OFS_SETUP_PRI: s_d.setup_pri = cfg_wdata_in & lcd_pkg::WM_SETUP_PRI;
        lcd_pkg::OFS_SETUP_SEC: s_d.setup_sec = cfg_wdata_in & lcd_pkg::WM_SETUP_SEC;
        lcd_pkg::OFS_BIOS_CTL:  s_d.bios_ctl  = cfg_wdata_in & lcd_pkg::WM_BIOS_CTL;
        lcd_pkg::OFS_PERF:      s_d.perf      = cfg_wdata_in & lcd_pkg::WM_PERF;
        lcd_pkg::OFS_WIN1_LO:   s_d.win1[7:0]  = cfg_wdata_in;
        lcd_pkg::OFS_WIN1_HI:   s_d.win1[15:8] = cfg_wdata_in;
        lcd_pkg::OFS_WIN2_LO:   s_d.win2[7:0]  = cfg_wdata_in;
        lcd_pkg::OFS_WIN2_HI:   s_d.win2[15:8] = cfg_wdata_in;
        lcd_pkg::OFS_MAP_LO:    s_d.map_lo    = cfg_wdata_in & lcd_pkg::WM_MAP_LO;
        lcd_pkg::OFS_MAP_HI:    s_d.map_hi    = cfg_wdata_in & lcd_pkg::WM_MAP_HI;
        default: ;
      endcase
    end
    // Register reads, unmapped offsets read zero
    if (cfg_rd_in) begin
      case (cfg_addr_in)
        lcd_pkg::OFS_SETUP_PRI: s_d.rdata = s_q.setup_pri;
        lcd_pkg::OFS_SETUP_SEC: s_d.rdata = s_q.setup_sec;
        lcd_pkg::OFS_BIOS_CTL:  s_d.rdata = s_q.bios_ctl;
        lcd_pkg::OFS_PERF:      s_d.rdata = s_q.perf;
        lcd_pkg::OFS_WIN1_LO:   s_d.rdata = s_q.win1[7:0];
        lcd_pkg::OFS_WIN1_HI:   s_d.rdata = s_q.win1[15:8];
        lcd_pkg::OFS_WIN2_LO:   s_d.rdata = s_q.win2[7:0];
        lcd_pkg::OFS_WIN2_HI:   s_d.rdata = s_q.win2[15:8];
        lcd_pkg::OFS_MAP_LO:    s_d.rdata = s_q.map_lo;
        lcd_pkg::OFS_MAP_HI:    s_d.rdata = s_q.map_hi;
        default:                s_d.rdata = 8'h00;
      endcase
    end

    mode        = s_q.setup_pri[lcd_pkg::MODE_LSB +: 2];
    tag         = s_q.setup_pri[lcd_pkg::TAG_LSB +: 2];
    forced_fill = s_q.bios_ctl[lcd_pkg::FILL_BIT];

    // Operating mode
    s_d.l2_enabled = (mode == lcd_pkg::MODE_NORMAL);
    s_d.l2_init    = (mode == lcd_pkg::MODE_INIT);

    // Tag layout
    case (tag)
      lcd_pkg::TAG_8_0:  s_d.tag_bits = 4'h8;
      lcd_pkg::TAG_7_1:  s_d.tag_bits = 4'h7;
      lcd_pkg::TAG_10_1: s_d.tag_bits = 4'hA;
      default:           s_d.tag_bits = 4'h9;
    endcase
    s_d.tag_modify = (tag != lcd_pkg::TAG_8_0);

    // SRAM type
    s_d.sram_present   = (s_q.setup_pri[lcd_pkg::SRAM_LSB +: 2] == lcd_pkg::SRAM_BURST) ||
                         (s_q.setup_pri[lcd_pkg::SRAM_LSB +: 2] == lcd_pkg::SRAM_PIPE);
    s_d.sram_pipelined = (s_q.setup_pri[lcd_pkg::SRAM_LSB +: 2] == lcd_pkg::SRAM_PIPE);

    // Size and burst timing
    s_d.size_kb = lcd_pkg::SIZE_MIN_KB << s_q.setup_sec[lcd_pkg::SIZE_LSB +: 2];
    if (beat_in == 3'h0) begin
      s_d.beat_clocks = lcd_pkg::LEAD_CLOCKS;
    end else if (s_q.setup_sec[lcd_pkg::BANKS_BIT] && beat_in == lcd_pkg::SWITCH_BEAT) begin
      s_d.beat_clocks = lcd_pkg::SWITCH_CLOCKS;
    end else begin
      s_d.beat_clocks = lcd_pkg::BURST_CLOCKS;
    end

    // BIOS segments
    in_c     = (hst_addr_in[31:15] == 17'h00018);
    in_d     = (hst_addr_in[31:16] == 16'h000D);
    in_e     = (hst_addr_in[31:16] == 16'h000E);
    in_f     = (hst_addr_in[31:16] == 16'h000F);
    seg_any  = in_c || in_d || in_e || in_f;
    seg_prot = (in_c && s_q.bios_ctl[lcd_pkg::WPC_BIT]) || (in_d && s_q.bios_ctl[lcd_pkg::WPD_BIT]) ||
               (in_e && s_q.bios_ctl[lcd_pkg::WPE_BIT]) || (in_f && s_q.bios_ctl[lcd_pkg::WPF_BIT]);

    // Uncached windows
    win1_hit = win_match(s_q.win1, hst_addr_in);
    win2_hit = win_match(s_q.win2, hst_addr_in);

    // Bank properties
    s_d.bank_cacheable = !((bank_index_in == 3'h2 || bank_index_in == 3'h3 || bank_index_in == 3'h4) &&
                           tag == lcd_pkg::TAG_10_1);
    s_d.populated = (s_q.map_hi[lcd_pkg::LAST_LSB +: 3] <= lcd_pkg::BANK_MAX) &&
                    (bank_index_in <= s_q.map_hi[lcd_pkg::LAST_LSB +: 3]);

    // Allocation and writes
    s_d.allocate = s_d.l2_enabled && s_d.sram_present && hst_read_in &&
                   (cpu_cacheable_in || forced_fill) &&
                   !win1_hit && !win2_hit &&
                   (!seg_any || seg_prot) &&
                   s_d.bank_cacheable && s_d.populated;
    s_d.write_through = s_q.bios_ctl[lcd_pkg::WPOL_BIT];
    s_d.l2_write   = (s_d.l2_enabled || s_d.l2_init) && s_d.sram_present && hst_write_in &&
                     !seg_prot && !win1_hit && !win2_hit && !(seg_any && !seg_prot);
    s_d.dram_write = hst_write_in && (seg_prot || s_d.write_through || !s_d.l2_write);

    // Forced fill stall
    if (fill_active_in && forced_fill && s_d.l2_enabled) begin
      s_d.burst_ready_strobe = s_q.setup_sec[lcd_pkg::BUS_BACKOFF_REQUEST_BIT] && burst_ready_strobe_request_in;
      s_d.bus_backoff_request = s_q.setup_sec[lcd_pkg::BUS_BACKOFF_REQUEST_BIT];
    end else begin
      s_d.burst_ready_strobe = burst_ready_strobe_request_in;
      s_d.bus_backoff_request = 1'b0;
    end

    // Ordering, pipelining and PCI
    s_d.read_first = s_q.perf[lcd_pkg::RAW_BIT] && hst_read_in && wbuf_pending_in;
    s_d.na = (pipe_read_hit_in && s_q.perf[lcd_pkg::CACHE_READ_PIPELINING_BIT]) ||
             (pipe_write_in && s_q.perf[lcd_pkg::CACHE_WRITE_PIPELINING_BIT]) ||
             (pipe_dram_in && s_q.perf[lcd_pkg::DPC_BIT]);
    s_d.pci_grant = pci_initiator_active_in && !s_q.perf[lcd_pkg::PEER_BIT];

    // Map type of the addressed bank pair
    case (bank_index_in[2:1])
      2'h0:    map_type = s_q.map_lo[lcd_pkg::MAPA_LSB +: 3];
      2'h1:    map_type = s_q.map_lo[lcd_pkg::MAPB_LSB +: 3];
      default: map_type = s_q.map_hi[lcd_pkg::MAPA_LSB +: 3];
    endcase
    s_d.sdram_64m = map_type[2];
    if (sdram_bank_in) begin
      col = lcd_pkg::COL_MIN + {3'h0, map_type[2]};
    end else if (map_type <= lcd_pkg::MAP_MAX) begin
      col = lcd_pkg::COL_MIN + {1'b0, map_type};
    end else begin
      col = lcd_pkg::COL_MIN;
    end
    s_d.col_bits = col;

    // Row and column address
    col_mask = 14'h3FFF >> (4'hE - col);
    row_addr = hst_addr_in >> (lcd_pkg::COL_LSB + int'(col));
    if (column_phase_in) begin
      s_d.ma = hst_addr_in[lcd_pkg::COL_LSB +: 14] & col_mask;
    end else begin
      s_d.ma = row_addr[13:0];
    end
    if (sdram_bank_in) begin
      if (column_phase_in) begin
        s_d.ma[lcd_pkg::PC_LINE] = !page_hit_in || all_bank_precharge_in;
      end
      if (sdram_four_bank_in) begin
        s_d.ma[13] = hst_addr_in[13];
      end else begin
        s_d.ma[11] = hst_addr_in[11];
      end
    end

    if (rst_in) begin
      s_d = '0;
      s_d.setup_pri = lcd_pkg::RST_SETUP_PRI;
      s_d.setup_sec = lcd_pkg::RST_SETUP_SEC;
      s_d.bios_ctl  = lcd_pkg::RST_BIOS_CTL;
      s_d.perf      = lcd_pkg::RST_PERF;
      s_d.win1      = lcd_pkg::RST_WIN;
      s_d.win2      = lcd_pkg::RST_WIN;
      s_d.map_lo    = lcd_pkg::RST_MAP_LO;
      s_d.map_hi    = lcd_pkg::RST_MAP_HI;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    s_q <= s_d;
  end

  assign cfg_rdata_out            = s_q.rdata;
  assign l2_enabled_out           = s_q.l2_enabled;
  assign l2_init_out              = s_q.l2_init;
  assign tag_bits_out             = s_q.tag_bits;
  assign tag_modify_out           = s_q.tag_modify;
  assign sram_present_out         = s_q.sram_present;
  assign sram_pipelined_out       = s_q.sram_pipelined;
  assign l2_size_kb_out           = s_q.size_kb;
  assign beat_clocks_out          = s_q.beat_clocks;
  assign l2_allocate_out          = s_q.allocate;
  assign l2_write_out             = s_q.l2_write;
  assign dram_write_out           = s_q.dram_write;
  assign write_through_out        = s_q.write_through;
  assign read_first_out           = s_q.read_first;
  assign pci_memory_grant_out     = s_q.pci_grant;
  assign bank_cacheable_out       = s_q.bank_cacheable;
  assign bank_populated_out       = s_q.populated;
  assign burst_ready_strobe_out   = s_q.burst_ready_strobe;
  assign bus_backoff_request_out  = s_q.bus_backoff_request;
  assign next_address_request_out = s_q.na;
  assign column_bits_out          = s_q.col_bits;
  assign sdram_64m_out            = s_q.sdram_64m;
  assign memory_address_line_out  = s_q.ma;

  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_mode_wr(logic [1:0] m);
    cfg_wr_in && cfg_addr_in == lcd_pkg::OFS_SETUP_PRI && cfg_wdata_in[7:6] == m;
  endsequence

  property p_mode_normal;
    s_mode_wr(lcd_pkg::MODE_NORMAL) |=> ##1 (l2_enabled_out && !l2_init_out);
  endproperty
  a_mode_normal: assert property (p_mode_normal) else $error("normal mode not reached");

  property p_mode_reserved;
    s_mode_wr(2'h3) |=> ##1 (!l2_enabled_out && !l2_init_out);
  endproperty
  a_mode_reserved: assert property (p_mode_reserved) else $error("reserved mode acted");

  property p_tag_10;
    (s_q.setup_pri[4:3] == lcd_pkg::TAG_10_1) |=> (tag_bits_out == 4'hA && tag_modify_out);
  endproperty
  a_tag_10: assert property (p_tag_10) else $error("tag layout 10+1 wrong");

  property p_backoff;
    (fill_active_in && s_q.bios_ctl[2] && s_q.setup_pri[7:6] == 2'h2) |=>
      (bus_backoff_request_out == $past(s_q.setup_sec[5]) && !($past(!s_q.setup_sec[5]) && burst_ready_strobe_out));
  endproperty
  a_backoff: assert property (p_backoff) else $error("forced fill stall wrong");

  property p_switch;
    (beat_in == 3'h4 && s_q.setup_sec[3]) |=> (beat_clocks_out == 2'h2);
  endproperty
  a_switch: assert property (p_switch) else $error("bank switch clock missing");

  property p_size;
    (s_q.setup_sec[1:0] == 2'h3) |=> (l2_size_kb_out == 12'h800);
  endproperty
  a_size: assert property (p_size) else $error("cache size wrong");

  property p_na_off;
    (s_q.perf[6:4] == 3'h0) |=> !next_address_request_out;
  endproperty
  a_na_off: assert property (p_na_off) else $error("next address without pipelining");

  property p_peer;
    (pci_initiator_active_in && !s_q.perf[3]) |=> pci_memory_grant_out;
  endproperty
  a_peer: assert property (p_peer) else $error("pci grant missing");

  property p_win;
    (win1_hit && hst_read_in) |=> !l2_allocate_out;
  endproperty
  a_win: assert property (p_win) else $error("allocate inside uncached window");

  property p_prot_write;
    (seg_prot && hst_write_in) |=> (!l2_write_out && dram_write_out);
  endproperty
  a_prot_write: assert property (p_prot_write) else $error("protected write reached L2");

  property p_pc;
    (sdram_bank_in && column_phase_in && !page_hit_in) |=> memory_address_line_out[10];
  endproperty
  a_pc: assert property (p_pc) else $error("precharge flag low on miss");

  property p_bank_tag;
    (bank_index_in == 3'h3 && s_q.setup_pri[4:3] == 2'h2) |=> !bank_cacheable_out;
  endproperty
  a_bank_tag: assert property (p_bank_tag) else $error("bank 3 cacheable under 10+1");

endmodule

// ---- lcd_host_model.sv ----
`timescale 1ns/1ps
module lcd_host_model (
  // Clock
  input  wire logic        sys_clk_in,
  // Cycle request from bench
  input  wire logic [31:0] req_addr_in,
  input  wire logic        req_read_in,
  input  wire logic        req_cacheable_in,
  // Processor bus
  output logic      [31:0] hst_addr_out,
  output logic             hst_read_out,
  output logic             cpu_cacheable_out
);
  initial begin
    hst_addr_out = 32'h0;
    hst_read_out = 1'b0;
    cpu_cacheable_out = 1'b0;
  end
  // Released address bus shows inverted last value
  always @(negedge sys_clk_in) begin
    hst_read_out <= req_read_in;
    cpu_cacheable_out <= req_cacheable_in;
    hst_addr_out <= req_read_in ? req_addr_in : ~hst_addr_out;
  end
endmodule

// ---- l2_cache_dram_map_config_tb.sv ----
`timescale 1ns/1ps
module l2_cache_dram_map_config_tb;
  logic        sys_clk_in, rst_in, cfg_wr_in, cfg_rd_in, hst_read_in, hst_write_in, cpu_cacheable_in;
  logic [7:0]  cfg_addr_in, cfg_wdata_in, cfg_rdata_out;
  logic [31:0] hst_addr_in, req_addr;
  logic [2:0]  bank_index_in, beat_in;
  logic        fill_active_in, burst_ready_strobe_request_in, wbuf_pending_in, pipe_read_hit_in, pipe_write_in, pipe_dram_in;
  logic        pci_initiator_active_in, sdram_bank_in, sdram_four_bank_in, column_phase_in, page_hit_in;
  logic        all_bank_precharge_in, req_read, req_cache;
  logic        l2_enabled_out, l2_init_out, tag_modify_out, sram_present_out, sram_pipelined_out;
  logic [3:0]  tag_bits_out, column_bits_out;
  logic [11:0] l2_size_kb_out;
  logic [1:0]  beat_clocks_out;
  logic        l2_allocate_out, l2_write_out, dram_write_out, write_through_out, read_first_out;
  logic        pci_memory_grant_out, bank_cacheable_out, bank_populated_out, sdram_64m_out;
  logic        burst_ready_strobe_out, bus_backoff_request_out, next_address_request_out;
  logic [13:0] memory_address_line_out;
  int          num_errors = 0;
  int          comparisons = 0;
  logic [7:0]  rv [11] = '{8'h20, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h05, 8'h00};
  logic [7:0]  wm [11] = '{8'hFB, 8'h2B, 8'hF7, 8'hF8, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hEE, 8'hE7, 8'h00};
  logic [3:0]  tg [4] = '{4'h8, 4'h7, 4'hA, 4'h9};

  lcd_config dut_u (.*);

  lcd_host_model host_u (
    .sys_clk_in        (sys_clk_in),
    .req_addr_in       (req_addr),
    .req_read_in       (req_read),
    .req_cacheable_in  (req_cache),
    .hst_addr_out      (hst_addr_in),
    .hst_read_out      (hst_read_in),
    .cpu_cacheable_out (cpu_cacheable_in)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  task report_and_stop;
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    cfg_addr_in = a;
    cfg_wdata_in = d;
    cfg_wr_in = 1'b1;
    @(negedge sys_clk_in);
    cfg_wr_in = 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk_in);
    cfg_addr_in = a;
    cfg_rd_in = 1'b1;
    @(negedge sys_clk_in);
    cfg_rd_in = 1'b0;
    chk($sformatf("reg %h", a), {8'h0, cfg_rdata_out}, {8'h0, e});
  endtask

  task step;
    repeat (2) @(negedge sys_clk_in);
  endtask

  task hst(input logic [31:0] a, input logic c, input logic e);
    req_addr <= a;
    req_cache <= c;
    req_read <= 1'b1;
    repeat (2) @(negedge sys_clk_in);
    chk("allocate", {15'h0, l2_allocate_out}, {15'h0, e});
  endtask

  initial begin
    {cfg_wr_in, cfg_rd_in, hst_write_in, fill_active_in, burst_ready_strobe_request_in, wbuf_pending_in} = '0;
    {pipe_read_hit_in, pipe_write_in, pipe_dram_in, pci_initiator_active_in, sdram_bank_in} = '0;
    {sdram_four_bank_in, column_phase_in, page_hit_in, all_bank_precharge_in, req_read, req_cache} = '0;
    {cfg_addr_in, cfg_wdata_in, req_addr, bank_index_in} = '0;
    beat_in = 3'h4;
    rst_in = 1'b1;
    repeat (6) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_in = 1'b0;
    for (int i = 0; i < 11; i++) rd(8'h50 + 8'(i), rv[i]);
    for (int i = 0; i < 11; i++) wr(8'h50 + 8'(i), 8'hFF);
    for (int i = 0; i < 11; i++) rd(8'h50 + 8'(i), wm[i]);
    for (int i = 0; i < 4; i++) begin
      wr(8'h50, {2'b10, 1'b1, i[1:0], 1'b0, i[1:0]});
      wr(8'h51, {4'h0, i[0], 1'b0, i[1:0]});
      step();
      chk("tag", {12'h0, tag_bits_out}, {12'h0, tg[i]});
      chk("modify", {15'h0, tag_modify_out}, {15'h0, i != 0});
      chk("sram", {14'h0, sram_present_out, sram_pipelined_out}, {14'h0, i[1], i == 3});
      chk("size", {4'h0, l2_size_kb_out}, 16'h100 << i);
      chk("beat", {14'h0, beat_clocks_out}, i[0] ? 16'h2 : 16'h1);
    end
    wr(8'h50, 8'hB3);
    wr(8'h59, 8'h04);
    for (int b = 0; b < 6; b++) begin
      bank_index_in = 3'(b);
      step();
      chk("bank cache", {15'h0, bank_cacheable_out}, {15'h0, !(b inside {2, 3, 4})});
      chk("populated", {15'h0, bank_populated_out}, {15'h0, b <= 4});
    end
    for (int m = 0; m < 3; m++) begin
      wr(8'h50, {m[1:0], 6'h23});
      step();
      chk("enable", {15'h0, l2_enabled_out}, {15'h0, m == 2});
      chk("init", {15'h0, l2_init_out}, {15'h0, m == 1});
    end
    bank_index_in = 3'h0;
    wr(8'h54, 8'h00);
    wr(8'h55, 8'h01);
    wr(8'h56, 8'h01);
    wr(8'h57, 8'h01);
    wr(8'h52, 8'h02);
    hst(32'h0000_8000, 1'b1, 1'b0);
    hst(32'h0020_8000, 1'b1, 1'b0);
    hst(32'h0001_0000, 1'b1, 1'b1);
    hst(32'h0001_0000, 1'b0, 1'b0);
    hst(32'h000C_0000, 1'b1, 1'b0);
    wr(8'h52, 8'h87);
    hst(32'h000C_0000, 1'b1, 1'b1);
    hst(32'h0001_0000, 1'b0, 1'b1);
    hst(32'h0000_8000, 1'b0, 1'b0);
    chk("write through", {15'h0, write_through_out}, 16'h1);
    {fill_active_in, burst_ready_strobe_request_in, pipe_read_hit_in, pci_initiator_active_in, sdram_bank_in, column_phase_in} = '1;
    for (int k = 0; k < 2; k++) begin
      page_hit_in = (k == 0);
      wr(8'h53, k ? 8'h00 : 8'h48);
      wr(8'h51, k ? 8'h20 : 8'h00);
      step();
      chk("next addr", {15'h0, next_address_request_out}, {15'h0, k == 0});
      chk("pci grant", {15'h0, pci_memory_grant_out}, {15'h0, k == 1});
      chk("precharge", {15'h0, memory_address_line_out[10]}, {15'h0, k == 1});
      chk("ready", {15'h0, burst_ready_strobe_out}, {15'h0, k == 1});
      chk("backoff", {15'h0, bus_backoff_request_out}, {15'h0, k == 1});
    end
    chk("columns", {12'h0, column_bits_out}, 16'h9);
    chk("64m", {15'h0, sdram_64m_out}, 16'h1);
    {sdram_bank_in, column_phase_in} = '0;
    wr(8'h58, 8'h60);
    step();
    chk("columns", {12'h0, column_bits_out}, 16'hB);
    chk("row", {2'h0, memory_address_line_out}, 16'h2);
    hst_write_in = 1'b1;
    hst(32'h000C_0000, 1'b1, 1'b1);
    chk("l2 write", {15'h0, l2_write_out}, 16'h0);
    chk("dram write", {15'h0, dram_write_out}, 16'h1);
    hst(32'h0001_0000, 1'b1, 1'b1);
    chk("l2 write", {15'h0, l2_write_out}, 16'h1);
    chk("dram write", {15'h0, dram_write_out}, 16'h1);
    wr(8'h52, 8'h84);
    step();
    chk("dram write", {15'h0, dram_write_out}, 16'h0);
    hst_write_in = 1'b0;
    wbuf_pending_in = 1'b1;
    step();
    chk("read first", {15'h0, read_first_out}, 16'h0);
    wr(8'h53, 8'h80);
    step();
    chk("read first", {15'h0, read_first_out}, 16'h1);
    beat_in = 3'h0;
    step();
    chk("beat", {14'h0, beat_clocks_out}, 16'h3);
    report_and_stop();
  end
endmodule
